// File: asbp_ctrl.sv
// host controller that drives an async sram byte port through its pins
// Functional notes
// - controller presents 19-bit address per access
// - unused chip select held low except during sleep
// - sleep control held high except in the sleep state
// - each cycle lasts at least 20 ns
`timescale 1ns/100ps
`default_nettype none
module asbp_ctrl
   import asbp_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // user side
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_sleep,
   input wire logic i_use_select,
   output logic o_busy,
   output logic o_rvalid,
   output logic [DATA_W-1:0] o_rdata,
   // memory pins
   output logic [ADDR_W-1:0] o_mem_addr,
   input wire logic [DATA_W-1:0] i_mem_dq,
   output logic [DATA_W-1:0] o_mem_dq,
   output logic o_mem_dq_oe,
   output logic o_chip_select_low,
   output logic o_write_strobe_low,
   output logic o_output_gate_low,
   output logic o_sleep_control_low
);
   asbp_state_t state_ff;
   asbp_state_t nxt_state;
   logic we_ff;
   logic use_sel_ff;
   logic [DATA_W-1:0] dq_sync1_ff;
   logic [DATA_W-1:0] dq_sync2_ff;
   logic timer_load;
   logic timer_done;
   logic rd_tail;
   logic [1:0] rd_pipe_ff;
   logic [CNT_W-1:0] strobe_len_ff;

   // ==========================================
   // strobe timer
   asbp_timer u_timer (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_load(timer_load),
      .i_count(STROBE_CYC),
      .o_done(timer_done)
   );
   assign timer_load = (state_ff == ASBP_SETUP);
   // a read still in the sampling pipe holds off the next request
   assign rd_tail = |rd_pipe_ff;

   // ==========================================
   // sequencer: setup, timed strobe, hold
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ASBP_IDLE:
            if (i_sleep)
               nxt_state = ASBP_SLEEP;
            else if (i_req && !rd_tail)
               nxt_state = ASBP_SETUP;
         ASBP_SETUP:
            nxt_state = ASBP_STROBE;
         ASBP_STROBE:
            if (timer_done)
               nxt_state = ASBP_HOLD;
         ASBP_HOLD:
            nxt_state = ASBP_IDLE;
         ASBP_SLEEP:
            if (!i_sleep)
               nxt_state = ASBP_IDLE;
         default:
            nxt_state = ASBP_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
         state_ff <= ASBP_IDLE;
      else
         state_ff <= nxt_state;
   end

   // ==========================================
   // request capture; address and data change only while strobe is high
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         o_mem_addr <= ADDR_RST;
         o_mem_dq <= DATA_RST;
         we_ff <= 1'b0;
      end
      else if (state_ff == ASBP_IDLE && nxt_state == ASBP_SETUP)
      begin
         o_mem_addr <= i_addr;
         o_mem_dq <= i_wdata;
         we_ff <= i_we;
      end
   end

   // select mode latched per access so the strap cannot glitch mid-cycle
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
         use_sel_ff <= 1'b1;
      else if (state_ff == ASBP_IDLE)
         use_sel_ff <= i_use_select;
   end

   // ==========================================
   // pin drive
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         o_chip_select_low <= 1'b1;
         o_write_strobe_low <= 1'b1;
         o_output_gate_low <= 1'b1;
         o_sleep_control_low <= 1'b1;
         o_mem_dq_oe <= 1'b0;
      end
      else
      begin
         // sleep only entered from idle, so no access is cut short
         o_sleep_control_low <= !(nxt_state == ASBP_SLEEP);
         // select held low when unused outside sleep, else framed on the access
         if (!use_sel_ff && nxt_state != ASBP_SLEEP)
            o_chip_select_low <= 1'b0;
         else
            o_chip_select_low <= !(nxt_state == ASBP_SETUP ||
               nxt_state == ASBP_STROBE || nxt_state == ASBP_HOLD);
         o_write_strobe_low <= !(nxt_state == ASBP_STROBE && we_ff);
         // gate only opens for reads, avoids a driver fight on writes
         o_output_gate_low <= !(!we_ff && (nxt_state == ASBP_STROBE ||
            nxt_state == ASBP_HOLD));
         // setup takes the fresh request, we_ff still holds the last one
         if (nxt_state == ASBP_SETUP)
            o_mem_dq_oe <= i_we;
         else
            o_mem_dq_oe <= we_ff && (nxt_state == ASBP_STROBE ||
               nxt_state == ASBP_HOLD);
      end
   end

   // ==========================================
   // read data: pin passes two flops before use
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         dq_sync1_ff <= DATA_RST;
         dq_sync2_ff <= DATA_RST;
      end
      else
      begin
         dq_sync1_ff <= i_mem_dq;
         dq_sync2_ff <= dq_sync1_ff;
      end
   end

   // sample lags the pins by two cycles; gate stays open through hold
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
         rd_pipe_ff <= 2'b00;
      else
         rd_pipe_ff <= {rd_pipe_ff[0],
            (state_ff == ASBP_HOLD) && !we_ff};
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         o_rvalid <= 1'b0;
         o_rdata <= DATA_RST;
      end
      else
      begin
         o_rvalid <= rd_pipe_ff[1];
         if (rd_pipe_ff[1])
            o_rdata <= dq_sync2_ff;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
         o_busy <= 1'b0;
      else
         o_busy <= (nxt_state != ASBP_IDLE) || rd_tail ||
            (state_ff == ASBP_HOLD && !we_ff);
   end

   // ==========================================
   // checks
   sequence s_write_strobe;
      !o_write_strobe_low ##1 o_write_strobe_low;
   endsequence

   // strobe length in cycles, read only by the checks below
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset || o_write_strobe_low)
         strobe_len_ff <= CNT_ZERO;
      else if (strobe_len_ff != ~CNT_ZERO)
         strobe_len_ff <= strobe_len_ff + CNT_ONE;
   end

   a_strobe_holds_addr: assert property (@(posedge i_ref_clk)
      disable iff (i_reset) !o_write_strobe_low |=> $stable(o_mem_addr))
      else $error("address moved during write strobe");

   a_strobe_min_len: assert property (@(posedge i_ref_clk)
      disable iff (i_reset) s_write_strobe |->
      (strobe_len_ff >= STROBE_CYC))
      else $error("write strobe too short");

   a_strobe_select: assert property (@(posedge i_ref_clk)
      disable iff (i_reset) !o_write_strobe_low |->
      !o_chip_select_low && o_sleep_control_low && o_mem_dq_oe)
      else $error("write strobe without select or data");

   a_no_fight: assert property (@(posedge i_ref_clk)
      disable iff (i_reset) o_mem_dq_oe |-> o_output_gate_low)
      else $error("gate open while host drives dq");

   a_sleep_quiet: assert property (@(posedge i_ref_clk)
      disable iff (i_reset) !o_sleep_control_low |->
      o_write_strobe_low && o_output_gate_low && !o_mem_dq_oe)
      else $error("activity during sleep");

   a_read_valid: assert property (@(posedge i_ref_clk)
      disable iff (i_reset) (state_ff == ASBP_HOLD && !we_ff) |->
      ##3 o_rvalid)
      else $error("read data not returned");
endmodule
`default_nettype wire

// File: asbp_mem_model.sv
// behavioural model of the byte wide static memory on the pins
`timescale 1ns/100ps
`default_nettype none
module asbp_mem_model
   import asbp_pkg::*;
(
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_dq,
   input wire logic i_chip_select_low,
   input wire logic i_write_strobe_low,
   input wire logic i_output_gate_low,
   input wire logic i_sleep_control_low,
   output logic [DATA_W-1:0] o_dq,
   output logic o_dq_oe
);
   // ==========
   // storage: sparse, so all words exist without the memory cost
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   // write is level sensitive; sleep blocks the input buffers
   always @(i_addr or i_dq or i_chip_select_low or i_write_strobe_low or
      i_sleep_control_low)
      if (!i_chip_select_low && i_sleep_control_low && !i_write_strobe_low)
         mem[i_addr] = i_dq;
   // drivers on only for a selected, awake, gated read
   assign o_dq_oe = !i_chip_select_low && i_sleep_control_low &&
      i_write_strobe_low && !i_output_gate_low;
   // unwritten words read as the inverted low address bits
   // explicit list: a write into the array alone would not wake @*
   always @(i_addr or i_chip_select_low or i_write_strobe_low or
      i_output_gate_low)
      o_dq = mem.exists(i_addr) ? mem[i_addr] : ~i_addr[7:0];
endmodule
`default_nettype wire

// File: asbp_pkg.sv
// package: constants for the async sram byte port controller
package asbp_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int WORDS = 524288;
   // cycle figures
   localparam int CLK_PERIOD_NS = 40;
   localparam int MIN_CYCLE_NS = 20;
   // least time rounds up, never below one cycle
   localparam int MIN_CYCLE_RAW =
      (MIN_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MIN_CYCLE_CYC = (MIN_CYCLE_RAW < 1) ? 1 : MIN_CYCLE_RAW;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'(MIN_CYCLE_CYC);
   localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   typedef enum logic [2:0] {
      ASBP_IDLE,
      ASBP_SETUP,
      ASBP_STROBE,
      ASBP_HOLD,
      ASBP_SLEEP
   } asbp_state_t;
endpackage

// File: asbp_timer.sv
// cycle timer: loads a count and flags when it has run down
`timescale 1ns/100ps
`default_nettype none
module asbp_timer
   import asbp_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_load,
   input wire logic [CNT_W-1:0] i_count,
   output logic o_done
);
   logic [CNT_W-1:0] cnt_ff;
   // ==========================================
   // down counter
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
         cnt_ff <= CNT_ZERO;
      else if (i_load)
         cnt_ff <= i_count;
      else if (cnt_ff != CNT_ZERO)
         cnt_ff <= cnt_ff - CNT_ONE;
   end
   // done once the count is at one or already spent
   assign o_done = (cnt_ff <= CNT_ONE) && !i_load;
endmodule
`default_nettype wire

// File: async_sram_byte_port_tb_top.sv
// self-checking testbench for the sram byte port controller
`timescale 1ns/100ps
`default_nettype none
module async_sram_byte_port_tb_top;
   import asbp_pkg::*;
   // ==========
   // stimulus and wires
   logic clk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0;
   logic slp = 1'b0, use_cs = 1'b1;
   logic [ADDR_W-1:0] addr = '0, maddr;
   logic [DATA_W-1:0] wd = '0, rd, hdq, ddq, dq, flt = 8'h3c;
   logic busy, rv, hoe, doe, cs_n, we_n, oe_n, sl_n;
   int err_total = 0;
   int n_tests = 0;
   always #20 clk = ~clk;
   // released lines wander so stale data never passes
   always @(posedge clk) flt <= ~flt;
   assign dq = hoe ? hdq : (doe ? ddq : flt);
   asbp_ctrl DUT (.i_ref_clk(clk), .i_reset(rst), .i_req(req), .i_we(we),
      .i_addr(addr), .i_wdata(wd), .i_sleep(slp), .i_use_select(use_cs),
      .o_busy(busy), .o_rvalid(rv), .o_rdata(rd), .o_mem_addr(maddr),
      .i_mem_dq(dq), .o_mem_dq(hdq), .o_mem_dq_oe(hoe),
      .o_chip_select_low(cs_n), .o_write_strobe_low(we_n),
      .o_output_gate_low(oe_n), .o_sleep_control_low(sl_n));
   asbp_mem_model MEM (.i_addr(maddr), .i_dq(dq), .i_chip_select_low(cs_n),
      .i_write_strobe_low(we_n), .i_output_gate_low(oe_n),
      .i_sleep_control_low(sl_n), .o_dq(ddq), .o_dq_oe(doe));
   // ==========
   // helpers
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   // one access; for reads d is the expected byte
   task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
      int n;
      int lo;
      logic got;
      lo = 0;
      got = w;
      req = 1'b1;
      we = w;
      addr = a;
      wd = d;
      tick();
      req = 1'b0;
      for (n = 0; !(got && busy === 1'b0); n++)
      begin
         if (n > 15)
            chk("access timeout", 1, 0);
         if (n > 15)
            test_done();
         tick();
         if (we_n === 1'b0)
         begin
            lo++;
            chk("gate in write", oe_n, 1);
            chk("addr in write", maddr, a);
            chk("data in write", {hoe, hdq}, {1'b1, d});
         end
         if (rv === 1'b1)
         begin
            got = 1'b1;
            chk("read data", rd, d);
         end
      end
      tick();
      if (w)
         chk("strobe long enough", lo >= MIN_CYCLE_CYC, 1);
      chk("memory drive idle", doe, 0);
   endtask
   // ==========
   // scenarios
   task automatic t_reset();
      chk("pins after reset", {cs_n, we_n, oe_n, sl_n, hoe, busy},
         6'h3c);
   endtask
   task automatic t_rw();
      acc(1, 19'h00000, 8'h5a);
      acc(1, 19'h7ffff, 8'hc3);
      acc(1, 19'h2a5a5, 8'h81);
      acc(0, 19'h7ffff, 8'hc3);
      acc(0, 19'h00000, 8'h5a);
      acc(0, 19'h2a5a5, 8'h81);
      acc(0, 19'h12345, 8'hba);
   endtask
   task automatic t_nosel();
      use_cs = 1'b0;
      tick();
      tick();
      chk("select tied", cs_n, 0);
      acc(1, 19'h00010, 8'h3e);
      acc(0, 19'h00010, 8'h3e);
      chk("select still tied", cs_n, 0);
      use_cs = 1'b1;
      tick();
      tick();
   endtask
   task automatic t_sleep();
      int n;
      slp = 1'b1;
      for (n = 0; n < 8 && sl_n !== 1'b0; n++)
         tick();
      chk("sleep pin", sl_n, 0);
      req = 1'b1;
      repeat (3) tick();
      chk("refused in sleep", {busy, doe, we_n, oe_n}, 4'hb);
      req = 1'b0;
      slp = 1'b0;
      for (n = 0; n < 8 && sl_n !== 1'b1; n++)
         tick();
      chk("awake pin", sl_n, 1);
      acc(0, 19'h2a5a5, 8'h81);
   endtask
   // ==========
   // main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      t_reset();
      t_rw();
      t_nosel();
      t_sleep();
      test_done();
   end
endmodule
`default_nettype wire
